// ==== rtl/pxo_pkg.sv ====
package pxo_pkg;
	localparam int unsigned REG_W = 16;
	localparam int unsigned PIX_W = 10;
	localparam int unsigned CNT_W = 18;
	localparam int unsigned ADR_W = 11;
	localparam int unsigned PIN_W = 4;

	// register offsets
	localparam logic [7:0] ADDR_ROW_CNT = 8'h03;
	localparam logic [7:0] ADDR_COL_CNT = 8'h04;
	localparam logic [7:0] ADDR_HBLANK = 8'h05;
	localparam logic [7:0] ADDR_VBLANK = 8'h06;
	localparam logic [7:0] ADDR_INTEG = 8'h09;
	localparam logic [7:0] ADDR_READ_MODE = 8'h20;

	// reset values
	localparam logic [15:0] RST_ROW_CNT = 16'h03ff;
	localparam logic [15:0] RST_COL_CNT = 16'h04ff;
	localparam logic [15:0] RST_HBLANK = 16'h0009;
	localparam logic [15:0] RST_VBLANK = 16'h0019;
	localparam logic [15:0] RST_INTEG = 16'h0419;
	localparam logic [15:0] RST_READ_MODE = 16'h0000;

	// field positions of the readout mode and integration registers
	localparam int unsigned SKIP_LSB = 0;
	localparam int unsigned SNAP_BIT = 8;
	localparam int unsigned RAW_BIT = 11;
	localparam int unsigned INTEG_MSB = 13;

	// timing counts in pixel clocks and rows
	localparam logic [15:0] HBLANK_MIN = 16'h0013;
	localparam logic [15:0] VBLANK_MIN = 16'h000f;
	localparam logic [17:0] P1_LEN = 18'h000f2;
	localparam logic [17:0] P2_BASE = 18'h00002;

	// array layout
	localparam logic [10:0] ARRAY_COLS = 11'h520;
	localparam logic [10:0] ARRAY_ROWS = 11'h418;
	localparam logic [10:0] BLACK_COL_FIRST = 11'h010;
	localparam logic [10:0] BLACK_ROW_FIRST = 11'h008;
	localparam logic [10:0] BLACK_LAST = 11'h007;
	localparam logic [10:0] WIN_MARGIN = 11'h004;

	// synchronised pin positions
	localparam int unsigned PIN_MCLK = 0;
	localparam int unsigned PIN_OE_N = 1;
	localparam int unsigned PIN_STBY = 2;
	localparam int unsigned PIN_TRIG = 3;

	typedef struct packed {
		logic [15:0] row_cnt;
		logic [15:0] col_cnt;
		logic [15:0] hblank;
		logic [15:0] vblank;
		logic [15:0] integ;
		logic [15:0] rmode;
	} pxo_cfg_t;

	typedef struct packed {
		logic [17:0] a_len;
		logic [17:0] p2_len;
		logic [17:0] row_len;
		logic [17:0] fv_rows;
		logic [17:0] frame_rows;
	} pxo_tim_t;

	typedef enum logic [2:0] {PH_IDLE, PH_P1, PH_ACT, PH_P2, PH_VB} pxo_phase_t;
endpackage : pxo_pkg

// ==== rtl/pxo_sync.sv ====
module pxo_sync #(
	parameter int unsigned W = 4
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// pins in and synchronised levels out
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} pxo_sync_st_t;

	pxo_sync_st_t st_ff;
	pxo_sync_st_t nxt_st;

	always_comb begin
		nxt_st.meta = pin_i;
		nxt_st.stable = st_ff.meta;
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sync_o = st_ff.stable;
endmodule : pxo_sync

// ==== rtl/pxo_tim_calc.sv ====
module pxo_tim_calc (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// configuration in, derived lengths out
	input wire pxo_pkg::pxo_cfg_t cfg_i,
	output pxo_pkg::pxo_tim_t tim_o
);
	function automatic logic [15:0] umax(input logic [15:0] a, input logic [15:0] b);
		umax = (a < b) ? b : a;
	endfunction : umax

	function automatic logic [15:0] eff_cols(input logic [15:0] c, input logic [1:0] skip);
		unique case (skip)
			2'd0: eff_cols = c;
			2'd1: eff_cols = {c[15:2], 1'b1};
			2'd2: eff_cols = {1'b0, c[15:3], 1'b1};
			2'd3: eff_cols = {2'b00, c[15:4], 1'b1};
		endcase
	endfunction : eff_cols

	pxo_pkg::pxo_tim_t st_ff;
	pxo_pkg::pxo_tim_t nxt_st;

	always_comb begin
		logic [15:0] hb;
		logic [15:0] vb;
		logic [17:0] nrm;
		logic [17:0] integ;
		hb = umax(cfg_i.hblank, pxo_pkg::HBLANK_MIN);
		vb = umax(cfg_i.vblank, pxo_pkg::VBLANK_MIN);
		// column skip shrinks the effective column count
		nxt_st.a_len = {2'b00, eff_cols(cfg_i.col_cnt, cfg_i.rmode[pxo_pkg::SKIP_LSB +: 2])}
			+ 18'd1;
		nxt_st.p2_len = pxo_pkg::P2_BASE + {2'b00, hb} - {2'b00, pxo_pkg::HBLANK_MIN};
		nxt_st.row_len = nxt_st.a_len + pxo_pkg::P1_LEN + nxt_st.p2_len;
		nxt_st.fv_rows = {2'b00, cfg_i.row_cnt} + 18'd1;
		nrm = nxt_st.fv_rows + {2'b00, vb} + 18'd1;
		integ = {4'h0, cfg_i.integ[pxo_pkg::INTEG_MSB:0]};
		nxt_st.frame_rows = (integ >= nrm) ? integ + 18'd1 : nrm;
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tim_o = st_ff;

	// lengths are zero until the first edge after reset has loaded them
	p2_min_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$past(rstn_i) |->
		st_ff.p2_len >= pxo_pkg::P2_BASE && st_ff.row_len >= st_ff.a_len + 18'd244)
		else $error("blanking shorter than its minimum");
endmodule : pxo_tim_calc

// ==== rtl/pxo_top.sv ====
module pxo_top (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// pins from outside the clock domain
	input wire logic master_clock_input_i,
	input wire logic out_en_n_i,
	input wire logic standby_i,
	input wire logic trigger_i,
	// pixel samples from the conversion path
	input wire logic [pxo_pkg::PIX_W-1:0] pix_sample_i,
	// register access, one whole word per strobe
	input wire logic reg_we_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [pxo_pkg::REG_W-1:0] reg_wdata_i,
	output logic [pxo_pkg::REG_W-1:0] reg_rdata_o,
	// pixel output pins
	output logic forwarded_pixel_clock_o,
	output logic [pxo_pkg::PIX_W-1:0] pix_data_o,
	output logic frame_active_o,
	output logic row_active_o,
	output logic strobe_o,
	output logic pins_oe_o,
	// array read address and analog control
	output logic [pxo_pkg::ADR_W-1:0] arr_col_o,
	output logic [pxo_pkg::ADR_W-1:0] arr_row_o,
	output logic bias_en_o
);
	typedef struct packed {
		pxo_pkg::pxo_cfg_t cfg;
		pxo_pkg::pxo_phase_t phase;
		logic [17:0] col;
		logic [17:0] row;
		logic mclk_prev;
		logic trig_prev;
		logic snap_req;
		logic forwarded_pixel_clock;
		logic [pxo_pkg::PIX_W-1:0] data;
		logic lv;
		logic fv;
		logic strobe;
		logic drive;
		logic bias;
		logic [pxo_pkg::ADR_W-1:0] arr_col;
		logic [pxo_pkg::ADR_W-1:0] arr_row;
		logic [pxo_pkg::REG_W-1:0] rdata;
	} pxo_top_st_t;

	pxo_top_st_t st_ff;
	pxo_top_st_t nxt_st;
	pxo_pkg::pxo_tim_t tim;
	logic [pxo_pkg::PIN_W-1:0] pins_s;
	logic mclk_s;
	logic oe_n_s;
	logic stby_s;
	logic trig_s;
	logic tick;
	logic can_start;
	logic trig_edge;

	pxo_sync #(
		.W(pxo_pkg::PIN_W)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.pin_i({trigger_i, standby_i, out_en_n_i, master_clock_input_i}),
		.sync_o(pins_s)
	);

	pxo_tim_calc u_calc (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.cfg_i(st_ff.cfg),
		.tim_o(tim)
	);

	assign mclk_s = pins_s[pxo_pkg::PIN_MCLK];
	assign oe_n_s = pins_s[pxo_pkg::PIN_OE_N];
	assign stby_s = pins_s[pxo_pkg::PIN_STBY];
	assign trig_s = pins_s[pxo_pkg::PIN_TRIG];
	// one pixel period per rising edge of the sampled master clock
	assign tick = mclk_s && !st_ff.mclk_prev;

	// free-running frames unless snapshot mode waits for the trigger
	// a trigger edge between pixel ticks is held in snap_req until a frame starts or standby clears it
	assign trig_edge = trig_s && !st_ff.trig_prev;
	assign can_start = !stby_s
		&& (!st_ff.cfg.rmode[pxo_pkg::SNAP_BIT] || st_ff.snap_req || trig_edge);

	function automatic logic [pxo_pkg::ADR_W-1:0] first_row(input logic raw);
		// raw mode starts at the top black rows, else inside the margin
		first_row = raw ? '0 : pxo_pkg::BLACK_ROW_FIRST + pxo_pkg::WIN_MARGIN;
	endfunction : first_row

	function automatic logic [pxo_pkg::REG_W-1:0] read_reg(input pxo_pkg::pxo_cfg_t c,
		input logic [7:0] a);
		unique case (a)
			pxo_pkg::ADDR_ROW_CNT: read_reg = c.row_cnt;
			pxo_pkg::ADDR_COL_CNT: read_reg = c.col_cnt;
			pxo_pkg::ADDR_HBLANK: read_reg = c.hblank;
			pxo_pkg::ADDR_VBLANK: read_reg = c.vblank;
			pxo_pkg::ADDR_INTEG: read_reg = c.integ;
			pxo_pkg::ADDR_READ_MODE: read_reg = c.rmode;
			default: read_reg = '0;
		endcase
	endfunction : read_reg

	always_comb begin
		nxt_st = st_ff;
		nxt_st.mclk_prev = mclk_s;
		nxt_st.trig_prev = trig_s;
		nxt_st.forwarded_pixel_clock = mclk_s;
		nxt_st.drive = !oe_n_s;
		nxt_st.bias = !stby_s;
		nxt_st.rdata = read_reg(st_ff.cfg, reg_addr_i);
		nxt_st.strobe = 1'b0;
		nxt_st.snap_req = st_ff.snap_req || trig_edge;

		// whole 16-bit words only
		if (reg_we_i) begin
			unique case (reg_addr_i)
				pxo_pkg::ADDR_ROW_CNT: nxt_st.cfg.row_cnt = reg_wdata_i;
				pxo_pkg::ADDR_COL_CNT: nxt_st.cfg.col_cnt = reg_wdata_i;
				pxo_pkg::ADDR_HBLANK: nxt_st.cfg.hblank = reg_wdata_i;
				pxo_pkg::ADDR_VBLANK: nxt_st.cfg.vblank = reg_wdata_i;
				pxo_pkg::ADDR_INTEG: nxt_st.cfg.integ = reg_wdata_i;
				pxo_pkg::ADDR_READ_MODE: nxt_st.cfg.rmode = reg_wdata_i;
				default: nxt_st.cfg = st_ff.cfg;
			endcase
		end

		// row skip is not part of the row or frame arithmetic, exposure stays put
		if (stby_s) begin
			nxt_st.phase = pxo_pkg::PH_IDLE;
			nxt_st.snap_req = 1'b0;
			nxt_st.lv = 1'b0;
			nxt_st.fv = 1'b0;
			nxt_st.col = '0;
			nxt_st.row = '0;
		end else if (tick) begin
			nxt_st.col = st_ff.col + 18'd1;
			unique case (st_ff.phase)
				pxo_pkg::PH_IDLE: begin
					if (can_start) begin
						nxt_st.phase = pxo_pkg::PH_P1;
						nxt_st.col = '0;
						nxt_st.row = '0;
						nxt_st.fv = 1'b1;
						nxt_st.snap_req = 1'b0;
						nxt_st.strobe = 1'b1;
						nxt_st.arr_row = first_row(st_ff.cfg.rmode[pxo_pkg::RAW_BIT]);
					end
				end
				pxo_pkg::PH_P1: begin
					if (st_ff.col == pxo_pkg::P1_LEN - 18'd1) begin
						nxt_st.phase = pxo_pkg::PH_ACT;
						nxt_st.col = '0;
						nxt_st.lv = 1'b1;
						nxt_st.data = pix_sample_i;
						nxt_st.arr_col = pxo_pkg::BLACK_COL_FIRST + pxo_pkg::WIN_MARGIN;
					end
				end
				pxo_pkg::PH_ACT: begin
					if (st_ff.col == tim.a_len - 18'd1) begin
						nxt_st.phase = pxo_pkg::PH_P2;
						nxt_st.col = '0;
						nxt_st.lv = 1'b0;
					end else begin
						nxt_st.data = pix_sample_i;
						nxt_st.arr_col = st_ff.arr_col + 11'd1;
					end
				end
				pxo_pkg::PH_P2: begin
					if (st_ff.col == tim.p2_len - 18'd1) begin
						nxt_st.col = '0;
						nxt_st.row = st_ff.row + 18'd1;
						nxt_st.arr_row = st_ff.arr_row + 11'd1;
						if (st_ff.row == tim.fv_rows - 18'd1) begin
							nxt_st.phase = pxo_pkg::PH_VB;
							nxt_st.fv = 1'b0;
						end else begin
							nxt_st.phase = pxo_pkg::PH_P1;
						end
					end
				end
				pxo_pkg::PH_VB: begin
					if (st_ff.col == tim.row_len - 18'd1) begin
						nxt_st.col = '0;
						nxt_st.row = st_ff.row + 18'd1;
						if (st_ff.row == tim.frame_rows - 18'd1) begin
							nxt_st.row = '0;
							nxt_st.phase = pxo_pkg::PH_IDLE;
							if (can_start) begin
								nxt_st.phase = pxo_pkg::PH_P1;
								nxt_st.fv = 1'b1;
								nxt_st.snap_req = 1'b0;
								nxt_st.strobe = 1'b1;
								nxt_st.arr_row = first_row(st_ff.cfg.rmode[pxo_pkg::RAW_BIT]);
							end
						end
					end
				end
				default: nxt_st.phase = pxo_pkg::PH_IDLE;
			endcase
		end else begin
			// strobe lasts a full pixel period
			nxt_st.strobe = st_ff.strobe;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff <= '0;
			st_ff.cfg.row_cnt <= pxo_pkg::RST_ROW_CNT;
			st_ff.cfg.col_cnt <= pxo_pkg::RST_COL_CNT;
			st_ff.cfg.hblank <= pxo_pkg::RST_HBLANK;
			st_ff.cfg.vblank <= pxo_pkg::RST_VBLANK;
			st_ff.cfg.integ <= pxo_pkg::RST_INTEG;
			st_ff.cfg.rmode <= pxo_pkg::RST_READ_MODE;
			st_ff.phase <= pxo_pkg::PH_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata_o = st_ff.rdata;
	assign forwarded_pixel_clock_o = st_ff.forwarded_pixel_clock;
	assign pix_data_o = st_ff.data;
	assign frame_active_o = st_ff.fv;
	assign row_active_o = st_ff.lv;
	assign strobe_o = st_ff.strobe;
	assign pins_oe_o = st_ff.drive;
	assign arr_col_o = st_ff.arr_col;
	assign arr_row_o = st_ff.arr_row;
	assign bias_en_o = st_ff.bias;

	// checking helpers: pixels per row and rows per frame
	logic [17:0] lv_run_ff;
	logic [17:0] fv_rows_ff;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lv_run_ff <= '0;
			fv_rows_ff <= '0;
		end else begin
			if (!st_ff.lv) begin
				lv_run_ff <= '0;
			end else if (tick) begin
				lv_run_ff <= lv_run_ff + 18'd1;
			end
			if (!st_ff.fv) begin
				fv_rows_ff <= '0;
			end else if (nxt_st.lv && !st_ff.lv) begin
				fv_rows_ff <= fv_rows_ff + 18'd1;
			end
		end
	end

	lv_in_fv_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		row_active_o |-> frame_active_o && st_ff.phase == pxo_pkg::PH_ACT)
		else $error("row active outside active data time");

	data_edge_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$changed(pix_data_o) |-> $rose(forwarded_pixel_clock_o))
		else $error("pixel data changed away from a rising pixel clock");

	clk_follow_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(mclk_s) |=> forwarded_pixel_clock_o ##1 $stable(forwarded_pixel_clock_o)
			|| !mclk_s)
		else $error("forwarded clock missed a master clock edge");

	row_len_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$fell(row_active_o) |-> $past(lv_run_ff) + 18'd1 == tim.a_len)
		else $error("active row length differs from column count plus one");

	pix_tick_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		row_active_o && tick |=> pix_data_o == $past(pix_sample_i) || !row_active_o)
		else $error("pixel not taken during active row");

	fv_rows_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$fell(frame_active_o) && !$past(stby_s) |-> fv_rows_ff == tim.fv_rows)
		else $error("frame active row count wrong");

	strobe_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(strobe_o) |-> $rose(frame_active_o) && st_ff.phase == pxo_pkg::PH_P1)
		else $error("strobe not at frame start");

	standby_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		stby_s |=> !frame_active_o && !row_active_o && !bias_en_o)
		else $error("readout continued in standby");

	tristate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		oe_n_s |=> !pins_oe_o)
		else $error("outputs driven while tristate requested");

	frame_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		$fell(frame_active_o));
	raw_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(frame_active_o) && st_ff.cfg.rmode[pxo_pkg::RAW_BIT]);
	snap_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(strobe_o) && st_ff.cfg.rmode[pxo_pkg::SNAP_BIT]);
	skip_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(row_active_o) && st_ff.cfg.rmode[pxo_pkg::SKIP_LSB +: 2] != 2'b00);
	float_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		$fell(pins_oe_o));

	arr_col_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(row_active_o) |-> arr_col_o == pxo_pkg::BLACK_COL_FIRST + pxo_pkg::WIN_MARGIN)
		else $error("row does not start at the first window column");

	first_row_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(frame_active_o) |-> arr_row_o == (st_ff.cfg.rmode[pxo_pkg::RAW_BIT] ? 11'h000
			: pxo_pkg::BLACK_ROW_FIRST + pxo_pkg::WIN_MARGIN))
		else $error("frame does not start at the expected array row");

	vb_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		st_ff.phase == pxo_pkg::PH_VB |-> !row_active_o && !frame_active_o)
		else $error("qualifier high during vertical blanking");

	snap_wait_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		st_ff.cfg.rmode[pxo_pkg::SNAP_BIT] && st_ff.phase == pxo_pkg::PH_IDLE
			&& !st_ff.snap_req && !trig_edge |=> !frame_active_o)
		else $error("snapshot frame started without a trigger");
endmodule : pxo_top

// ==== verif/pxo_host_model.sv ====
module pxo_host_model (
	// pixel pins seen by the capture logic
	input wire logic forwarded_pixel_clock_i,
	input wire logic [pxo_pkg::PIX_W-1:0] pix_data_i,
	input wire logic frame_active_i,
	input wire logic row_active_i,
	input wire logic pins_oe_i,
	// capture statistics
	output logic [15:0] rows_o,
	output logic [15:0] last_act_o,
	output logic [15:0] last_gap_o,
	output logic [15:0] dups_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic prev_lv;
	logic prev_fv;
	logic in_row;
	logic [15:0] act;
	logic [15:0] gap;
	logic [pxo_pkg::PIX_W-1:0] prev_pix;

	initial begin
		{prev_lv, prev_fv, in_row, act, gap, prev_pix} = '0;
		{rows_o, last_act_o, last_gap_o, dups_o} = '0;
	end

	// latch on the falling edge where data is settled; floated pins carry nothing
	always @(negedge forwarded_pixel_clock_i) begin
		if (pins_oe_i === 1'b1) begin
			if (frame_active_i === 1'b1 && !prev_fv) begin
				rows_o = '0;
				in_row = 1'b0;
			end
			if (row_active_i === 1'b1) begin
				if (!prev_lv) begin
					if (in_row) last_gap_o = gap;
					act = 16'h0001;
				end else begin
					act = act + 16'h0001;
					if (pix_data_i === prev_pix) dups_o = dups_o + 16'h0001;
				end
				prev_pix = pix_data_i;
			end else if (prev_lv) begin
				last_act_o = act;
				rows_o = rows_o + 16'h0001;
				in_row = 1'b1;
				gap = 16'h0001;
			end else begin
				gap = gap + 16'h0001;
			end
			prev_lv = row_active_i;
			prev_fv = frame_active_i;
		end
	end
endmodule : pxo_host_model

// ==== verif/sensor_pixel_output_timing_bench.sv ====
module sensor_pixel_output_timing_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, rstn, mclk, oe_n, stby, trig, we;
	logic [pxo_pkg::PIX_W-1:0] pix, pdat;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, rows, last_act, last_gap, dups;
	logic pclk, fv, lv, strobe, oe, bias;
	logic [10:0] acol, arow;
	int n_errors = 0;
	int tests_run = 0;
	int k, k1, k2;
	logic [15:0] cm [4] = '{16'h0000, 16'h0001, 16'h0102, 16'h0803};
	logic [15:0] col [4] = '{16'h0007, 16'h001f, 16'h001f, 16'h001f};
	logic [15:0] hb [4] = '{16'h0009, 16'h0019, 16'h0013, 16'h0009};
	logic [15:0] ea [4] = '{16'h0008, 16'h0010, 16'h0008, 16'h0004};
	logic [15:0] eg [4] = '{16'h00f4, 16'h00fa, 16'h00f4, 16'h00f4};

	pxo_top pxo_top_i (
		.core_clk_i(clk), .rstn_i(rstn), .master_clock_input_i(mclk), .out_en_n_i(oe_n),
		.standby_i(stby), .trigger_i(trig), .pix_sample_i(pix), .reg_we_i(we),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.forwarded_pixel_clock_o(pclk), .pix_data_o(pdat), .frame_active_o(fv),
		.row_active_o(lv), .strobe_o(strobe), .pins_oe_o(oe), .arr_col_o(acol),
		.arr_row_o(arow), .bias_en_o(bias)
	);

	pxo_host_model pxo_host_model_i (
		.forwarded_pixel_clock_i(pclk), .pix_data_i(pdat), .frame_active_i(fv),
		.row_active_i(lv), .pins_oe_i(oe), .rows_o(rows), .last_act_o(last_act),
		.last_gap_o(last_gap), .dups_o(dups)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// master clock pin, phase unrelated to the core clock
	initial begin
		mclk = 1'b0;
		#33;
		forever #80 mclk = ~mclk;
	end

	// a fresh sample every core cycle so consecutive pixels always differ
	always @(posedge clk) pix <= pix + 10'h001;

	task automatic end_sim();
		$display("compares %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		repeat (3) @(posedge clk);
		chk("reg_rdata", rdata, exp);
	endtask : rd

	// bounded wait for frame_active (sel_fv) or the forwarded clock to reach a level
	task automatic wait_on(input bit sel_fv, input logic lvl, output int n);
		n = 0;
		while ((sel_fv ? fv : pclk) !== lvl) begin
			@(posedge clk);
			n++;
			if (n > 40000) begin
				n_errors++;
				$display("unexpected wait timeout expected %0h", lvl);
				end_sim();
			end
		end
	endtask : wait_on

	initial begin
		{oe_n, stby, trig, we, addr, wdata, pix} = '0;
		rstn = 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(pxo_pkg::ADDR_ROW_CNT, pxo_pkg::RST_ROW_CNT);
		rd(pxo_pkg::ADDR_COL_CNT, pxo_pkg::RST_COL_CNT);
		rd(pxo_pkg::ADDR_HBLANK, pxo_pkg::RST_HBLANK);
		rd(pxo_pkg::ADDR_VBLANK, pxo_pkg::RST_VBLANK);
		rd(pxo_pkg::ADDR_INTEG, pxo_pkg::RST_INTEG);
		rd(pxo_pkg::ADDR_READ_MODE, pxo_pkg::RST_READ_MODE);
		wr(8'h07, 16'hffff);
		rd(8'h07, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			stby <= 1'b1;
			repeat (8) @(posedge clk);
			chk("bias_en", bias, 1'b0);
			chk("frame_active", fv, 1'b0);
			chk("row_active", lv, 1'b0);
			wr(pxo_pkg::ADDR_ROW_CNT, 16'h0002);
			wr(pxo_pkg::ADDR_COL_CNT, col[i]);
			wr(pxo_pkg::ADDR_HBLANK, hb[i]);
			wr(pxo_pkg::ADDR_VBLANK, 16'h000f);
			wr(pxo_pkg::ADDR_READ_MODE, cm[i]);
			rd(pxo_pkg::ADDR_COL_CNT, col[i]);
			stby <= 1'b0;
			repeat (8) @(posedge clk);
			chk("bias_en", bias, 1'b1);
			// snapshot mode: no frame until the trigger pin rises
			if (cm[i][pxo_pkg::SNAP_BIT]) begin
				repeat (40) @(posedge clk);
				chk("snap_idle", fv, 1'b0);
				trig <= 1'b1;
				repeat (4) @(posedge clk);
				trig <= 1'b0;
			end
			wait_on(1'b1, 1'b1, k);
			chk("strobe", strobe, 1'b1);
			chk("first_row", arow, cm[i][pxo_pkg::RAW_BIT] ? 32'h0
				: pxo_pkg::BLACK_ROW_FIRST + pxo_pkg::WIN_MARGIN);
			wait_on(1'b1, 1'b0, k);
			chk("last_col", acol, pxo_pkg::BLACK_COL_FIRST + pxo_pkg::WIN_MARGIN + ea[i] - 1);
			chk("rows_per_frame", rows, 16'h0003);
			chk("active_len", last_act, ea[i]);
			chk("hblank_len", last_gap, eg[i]);
		end
		// forwarded clock measured during vertical blanking
		wait_on(1'b0, 1'b0, k);
		wait_on(1'b0, 1'b1, k);
		wait_on(1'b0, 1'b0, k1);
		wait_on(1'b0, 1'b1, k2);
		chk("pclk_high", k1, 32'h8);
		chk("pclk_period", k1 + k2, 32'h10);
		chk("dup_pixels", dups, 16'h0000);
		oe_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk("pins_oe", oe, 1'b0);
		oe_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk("pins_oe", oe, 1'b1);
		rstn <= 1'b0;
		@(posedge clk);
		chk("frame_active", fv, 1'b0);
		rstn <= 1'b1;
		rd(pxo_pkg::ADDR_COL_CNT, pxo_pkg::RST_COL_CNT);
		end_sim();
	end
endmodule : sensor_pixel_output_timing_bench
